// ---- shared/dcsp_defines.vh ----
// constants for the decimator control and serial port block
`ifndef DCSP_DEFINES_VH
`define DCSP_DEFINES_VH

// ==========================================================
// word widths
`define DCSP_RES_W 24
`define DCSP_STAT_W 8
`define DCSP_CFG_W 8
`define DCSP_CNT_W 5

// ==========================================================
// configuration register fields
`define DCSP_CFG_RATE_HI 7
`define DCSP_CFG_RATE_LO 5
`define DCSP_CFG_MOD_HI 4
`define DCSP_CFG_MOD_LO 0
`define DCSP_CFG_RST 8'h00

// ==========================================================
// status register fields
`define DCSP_ST_ERROR 7
`define DCSP_ST_READY 6
`define DCSP_ST_POWER_DOWN 5
`define DCSP_ST_NEEDSYNC 4
`define DCSP_ST_OVR 3
`define DCSP_ST_FILT_ERR 2

// ==========================================================
// modulator clock divider, in master clock edges
`define DCSP_MCLK_DIV 4
`define DCSP_MCLK_DIV_W 2

`endif

// ---- design/dcsp_edge_detect.v ----
// edge detector for inputs already synchronous to the system clock
`timescale 1ns/10ps

module dcsp_edge_detect #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  input wire ce,
  // sampled level and its edges
  input wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] prev_q;

  // ==========================================================
  // previous level, frozen with the clock enable
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      prev_q <= level;
    end
  end

  // edges are qualified by ce so a frozen block sees no events
  assign rise = {WIDTH{ce}} & level & ~prev_q;
  assign fall = {WIDTH{ce}} & ~level & prev_q;

endmodule

// ---- design/dcsp_out_shift.v ----
// parallel-load shift register driving the serial data output, msb first
`timescale 1ns/10ps

module dcsp_out_shift #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  input wire ce,
  // control
  input wire load,
  input wire [WIDTH-1:0] load_data,
  input wire shift,
  // serial bit, registered
  output wire bit_out
);

  reg [WIDTH-1:0] sr_q;

  // ==========================================================
  // load wins over shift so a fresh read never starts one bit late
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (load) begin
        sr_q <= load_data;
      end else if (shift) begin
        sr_q <= {sr_q[WIDTH-2:0], 1'b0};
      end
    end
  end

  assign bit_out = sr_q[WIDTH-1];

endmodule

// ---- design/dcsp_top.v ----
// control logic and serial port of a decimating filter device
// How it works
// - read data leaves msb first, changing on serial clock rising edges
// - register select high returns the result, low returns the status word
// - result ready rises on a new result, falls once a result read completes
// - with chip select high the serial pins are ignored and output floats
// - read/write high starts a read; low floats output and accepts a write
// - write bits msb first on falling edges, shifted in, then loaded into config
// - a modulator or filter error pulls fault low and sets the status error bit
// - fault is open drain only, so several devices can share the wire
// - chip reset clears errors and loads config from the hardware pins
// - power-down halts convolutions and modulator clock, keeps registers and port
// - power-down starts on the first falling master clock edge after request
// - filter input is test data when source select high, else modulator bits
// - sync clears the filter on the first master clock rising edge after it rises
// - a sync in step with the decimation period does not restart convolution
// - modulator clock is the master clock divided by four
// - decimator reset input holds the filter decimator in reset
// - overrange is sampled on master rising edges and raises the fault
// - modulator control: low three bits gain/standby, high two bits input mux
// - mode pin high follows hardware pins, low uses the last serial write
// - rate pins set decimation rate and config bits at reset or in hardware mode
`timescale 1ns/10ps
`include "dcsp_defines.vh"

module dcsp_top (
  // system clock, reset and freeze
  input wire clk,
  input wire arst_n,
  input wire ce,
  // device control pins
  input wire chip_reset,
  input wire decimator_reset,
  input wire power_down,
  input wire sync_in,
  input wire hw_mode,
  input wire [2:0] rate_select_pins,
  input wire [4:0] modulator_control_pins,
  // serial port
  input wire cs_n,
  input wire sclk,
  input wire read_not_write,
  input wire register_select,
  input wire din,
  output reg dout_o,
  output reg dout_oe,
  output reg result_ready,
  // fault line, open drain
  output reg fault_n_o,
  output reg fault_n_oe,
  // modulator side
  input wire master_clock_in,
  input wire modulator_bitstream_in,
  input wire modulator_overrange_in,
  input wire test_data_in,
  input wire filter_source_select,
  output reg modulator_clock_out,
  output reg [4:0] modulator_control_out,
  // filter core side
  input wire result_strobe,
  input wire [23:0] result_data,
  input wire period_start,
  input wire filter_error,
  output reg filter_bit,
  output reg filter_bit_strobe,
  output reg filter_clear,
  output reg decimator_hold,
  output reg convolve_enable,
  output reg [2:0] decimation_rate
);

  // ==========================================================
  // edge detection of the serial clock, master clock and sync input
  wire sclk_rise;
  wire sclk_fall;
  wire mck_rise;
  wire mck_fall;
  wire sync_rise;
  dcsp_edge_detect #(.WIDTH(2)) u_clk_edge (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .level({master_clock_in, sclk}),
    .rise({mck_rise, sclk_rise}),
    .fall({mck_fall, sclk_fall})
  );

  dcsp_edge_detect #(.WIDTH(1)) u_sync_edge (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .level(sync_in),
    .rise(sync_rise),
    .fall()
  );

  // ==========================================================
  // state registers
  reg [`DCSP_CFG_W-1:0] cfg_sw_q;
  reg [`DCSP_CFG_W-1:0] wr_sr_q;
  reg [`DCSP_CNT_W-1:0] wr_cnt_q;
  reg rd_active_q;
  reg rd_sel_q;
  reg rd_done_q;
  reg [`DCSP_CNT_W-1:0] rd_cnt_q;
  reg error_q;
  reg ovr_q;
  reg filt_err_q;
  reg pd_q;
  reg need_sync_q;
  reg sync_pend_q;
  reg [`DCSP_MCLK_DIV_W-1:0] mck_cnt_q;

  // ==========================================================
  // port qualification
  wire port_on = ~cs_n;
  wire rd_req = port_on & read_not_write;
  wire wr_req = port_on & ~read_not_write;
  wire rd_start = rd_req & ~rd_active_q & ~rd_done_q;
  wire rd_complete = rd_active_q & rd_req & sclk_fall & (rd_cnt_q == (rd_sel_q ? `DCSP_RES_W - 1 : `DCSP_STAT_W - 1));

  // ==========================================================
  // effective configuration: pins in hardware mode, serial word otherwise
  wire [`DCSP_CFG_W-1:0] cfg_pins = {rate_select_pins, modulator_control_pins};
  wire [`DCSP_CFG_W-1:0] cfg_eff = hw_mode ? cfg_pins : cfg_sw_q;

  // ==========================================================
  // status word and read data selection
  wire [`DCSP_STAT_W-1:0] status_word;
  assign status_word[`DCSP_ST_ERROR] = error_q;
  assign status_word[`DCSP_ST_READY] = result_ready;
  assign status_word[`DCSP_ST_POWER_DOWN] = pd_q;
  assign status_word[`DCSP_ST_NEEDSYNC] = need_sync_q;
  assign status_word[`DCSP_ST_OVR] = ovr_q;
  assign status_word[`DCSP_ST_FILT_ERR] = filt_err_q;
  assign status_word[1:0] = 2'h0;

  // status sits in the top bits so both words leave msb first
  wire [`DCSP_RES_W-1:0] rd_word = register_select ? result_data :
                                   {status_word, {(`DCSP_RES_W-`DCSP_STAT_W){1'b0}}};
  wire shift_bit;

  dcsp_out_shift #(.WIDTH(`DCSP_RES_W)) u_out_shift (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .load(rd_start),
    .load_data(rd_word),
    .shift(rd_active_q & rd_req & sclk_rise),
    .bit_out(shift_bit)
  );

  // ==========================================================
  // read sequencer: one word per chip select, bit count on falling edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_active_q <= 1'b0;
      rd_sel_q <= 1'b0;
      rd_done_q <= 1'b0;
      rd_cnt_q <= {`DCSP_CNT_W{1'b0}};
    end else if (ce) begin
      if (!rd_req) begin
        // deselect or turn to write ends the read, finished or not
        rd_active_q <= 1'b0;
        rd_done_q <= 1'b0;
        rd_cnt_q <= {`DCSP_CNT_W{1'b0}};
      end else if (rd_start) begin
        rd_active_q <= 1'b1;
        rd_sel_q <= register_select;
        rd_cnt_q <= {`DCSP_CNT_W{1'b0}};
      end else if (rd_complete) begin
        // extra clocks after the last bit shift nothing; the output stays zero, no reload
        rd_active_q <= 1'b0;
        rd_done_q <= 1'b1;
      end else if (rd_active_q && sclk_fall) begin
        rd_cnt_q <= rd_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // serial output pin, floated unless a read is selected
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_o <= 1'b0;
      dout_oe <= 1'b0;
    end else if (ce) begin
      dout_o <= shift_bit;
      dout_oe <= rd_req;
    end
  end

  // ==========================================================
  // result ready: a new result sets, a completed result read clears
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_ready <= 1'b0;
    end else if (ce) begin
      if (result_strobe) begin
        result_ready <= 1'b1;
      end else if (rd_complete && rd_sel_q) begin
        result_ready <= 1'b0;
      end
    end
  end

  // ==========================================================
  // write path: shift on falling serial clock, load after a whole word
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_sr_q <= {`DCSP_CFG_W{1'b0}};
      wr_cnt_q <= {`DCSP_CNT_W{1'b0}};
      cfg_sw_q <= `DCSP_CFG_RST;
    end else if (ce) begin
      if (chip_reset) begin
        cfg_sw_q <= cfg_pins;
        wr_cnt_q <= {`DCSP_CNT_W{1'b0}};
      end else if (!wr_req) begin
        wr_cnt_q <= {`DCSP_CNT_W{1'b0}};
      end else if (sclk_fall) begin
        wr_sr_q <= {wr_sr_q[`DCSP_CFG_W-2:0], din};
        if (wr_cnt_q == `DCSP_CFG_W - 1) begin
          cfg_sw_q <= {wr_sr_q[`DCSP_CFG_W-2:0], din};
          wr_cnt_q <= {`DCSP_CNT_W{1'b0}};
        end else begin
          wr_cnt_q <= wr_cnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // configuration outputs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modulator_control_out <= 5'h00;
      decimation_rate <= 3'h0;
    end else if (ce) begin
      // bits 2:0 gain or standby code, bits 4:3 input mux
      modulator_control_out <= cfg_eff[`DCSP_CFG_MOD_HI:`DCSP_CFG_MOD_LO];
      decimation_rate <= cfg_eff[`DCSP_CFG_RATE_HI:`DCSP_CFG_RATE_LO];
    end
  end

  // ==========================================================
  // error capture; sticky until chip reset, a new event beats the clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      error_q <= 1'b0;
      ovr_q <= 1'b0;
      filt_err_q <= 1'b0;
    end else if (ce) begin
      if (mck_rise && modulator_overrange_in) begin
        ovr_q <= 1'b1;
        error_q <= 1'b1;
      end else if (chip_reset) begin
        ovr_q <= 1'b0;
      end
      if (filter_error) begin
        filt_err_q <= 1'b1;
        error_q <= 1'b1;
      end else if (chip_reset) begin
        filt_err_q <= 1'b0;
        if (!(mck_rise && modulator_overrange_in)) begin
          error_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // fault pin only ever pulls low; the pull-up lives outside this logic
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b0;
    end else if (ce) begin
      fault_n_o <= 1'b0;
      fault_n_oe <= error_q;
    end
  end

  // ==========================================================
  // power-down and sync bookkeeping, stepped on master clock edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_q <= 1'b0;
      need_sync_q <= 1'b0;
    end else if (ce) begin
      if (mck_fall) begin
        if (power_down && !pd_q) begin
          pd_q <= 1'b1;
        end else if (!power_down && pd_q) begin
          pd_q <= 1'b0;
          need_sync_q <= 1'b1;
        end
      end
      // the sync that releases the filter is taken at the rising edge
      if (mck_rise && (sync_pend_q || sync_rise) && !pd_q) begin
        need_sync_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sync: remembered until the next master rising edge, then cleared
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_pend_q <= 1'b0;
      filter_clear <= 1'b0;
    end else if (ce) begin
      filter_clear <= 1'b0;
      if (mck_rise) begin
        sync_pend_q <= 1'b0;
        // a sync aligned to the period start leaves the cycle running
        if ((sync_pend_q || sync_rise) && !period_start) begin
          filter_clear <= 1'b1;
        end
      end else if (sync_rise) begin
        sync_pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // modulator clock divider, stopped during power-down
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mck_cnt_q <= {`DCSP_MCLK_DIV_W{1'b0}};
      modulator_clock_out <= 1'b0;
    end else if (ce) begin
      if (!pd_q && (mck_rise || mck_fall)) begin
        // count both master edges: one output period per DIV master periods
        mck_cnt_q <= mck_cnt_q + 1'b1;
        if (mck_cnt_q == `DCSP_MCLK_DIV - 1) begin
          modulator_clock_out <= ~modulator_clock_out;
        end
      end
    end
  end

  // ==========================================================
  // filter input mux, sampled on master rising edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_bit <= 1'b0;
      filter_bit_strobe <= 1'b0;
    end else if (ce) begin
      filter_bit_strobe <= mck_rise & ~pd_q;
      if (mck_rise) begin
        filter_bit <= filter_source_select ? test_data_in : modulator_bitstream_in;
      end
    end
  end

  // ==========================================================
  // decimator hold and convolution enable to the filter core
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decimator_hold <= 1'b0;
      convolve_enable <= 1'b0;
    end else if (ce) begin
      decimator_hold <= decimator_reset;
      convolve_enable <= ~pd_q & ~need_sync_q & ~decimator_reset;
    end
  end

endmodule

// ---- dv/dcsp_monitor.sv ----
// port-level checker for the decimator control and serial port block
`timescale 1ns/10ps

module dcsp_monitor (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // inputs watched
  input wire cs_n,
  input wire read_not_write,
  input wire result_strobe,
  input wire decimator_reset,
  input wire hw_mode,
  input wire [2:0] rate_select_pins,
  input wire [4:0] modulator_control_pins,
  input wire power_down,
  input wire chip_reset,
  input wire filter_error,
  input wire modulator_overrange_in,
  // outputs watched
  input wire dout_oe,
  input wire result_ready,
  input wire fault_n_o,
  input wire fault_n_oe,
  input wire decimator_hold,
  input wire [4:0] modulator_control_out,
  input wire [2:0] decimation_rate,
  input wire filter_bit_strobe,
  input wire convolve_enable,
  input wire modulator_clock_out,
  input wire filter_clear
);
  reg [3:0] pd_cnt_q;

  // ==========================================================
  // helper: consecutive power-down cycles, saturating, long enough to cover one master fall
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) pd_cnt_q <= 4'h0;
    else if (!power_down) pd_cnt_q <= 4'h0;
    else if (pd_cnt_q != 4'hF) pd_cnt_q <= pd_cnt_q + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // assertions
  a_oe_idle: assert property ($past(cs_n) |-> !dout_oe)
    else $error("data output driven while deselected");
  a_oe_write: assert property ($past(!read_not_write) |-> !dout_oe)
    else $error("data output driven during a write");
  a_fault_drain: assert property (fault_n_o == 1'h0)
    else $error("fault line driven high");
  a_ready_cause: assert property ($rose(result_ready) |-> $past(result_strobe))
    else $error("result ready rose without a new result");
  a_ready_new: assert property (result_strobe |=> result_ready)
    else $error("result ready missing after a new result");
  a_hold_follow: assert property (decimator_reset [*2] |-> decimator_hold)
    else $error("decimator not held in reset");
  a_cfg_pins: assert property ((hw_mode && $stable({rate_select_pins, modulator_control_pins})) [*3]
    |-> {decimation_rate, modulator_control_out} == {rate_select_pins, modulator_control_pins})
    else $error("configuration does not follow pins");
  a_pd_halt: assert property (pd_cnt_q == 4'hF |-> !filter_bit_strobe && !convolve_enable
    && $stable(modulator_clock_out))
    else $error("activity during power-down");
  a_err_fault: assert property (filter_error && !chip_reset |-> ##[1:2] fault_n_oe)
    else $error("filter error did not pull fault");
  a_ovr_fault: assert property ((modulator_overrange_in && !chip_reset) [*8] |-> ##[0:4] fault_n_oe)
    else $error("overrange did not pull fault");

  // ==========================================================
  // scenario coverage
  c_read_done: cover property ($fell(result_ready));
  c_pd: cover property (pd_cnt_q == 4'hF);
  c_clear: cover property (filter_clear);
endmodule

bind dcsp_top dcsp_monitor u_mon (.clk, .arst_n, .cs_n, .read_not_write, .result_strobe, .decimator_reset,
  .hw_mode, .rate_select_pins, .modulator_control_pins, .power_down, .chip_reset, .filter_error,
  .modulator_overrange_in, .dout_oe, .result_ready, .fault_n_o, .fault_n_oe, .decimator_hold,
  .modulator_control_out, .decimation_rate, .filter_bit_strobe, .convolve_enable, .modulator_clock_out,
  .filter_clear);

// ---- dv/dcsp_mod_model.sv ----
// behavioural sigma-delta modulator facing the device
`timescale 1ns/10ps

module dcsp_mod_model (
  // sampling clock from the device
  input wire clk,
  input wire mclk,
  // bench command
  input wire ovr_req,
  // bitstream and overrange back to the device
  output reg bits,
  output reg ovr
);
  reg mclk_q = 1'h0;

  // ==========================================================
  // new bit on each sampling clock rise; a stopped clock freezes the stream
  always @(posedge clk) begin
    mclk_q <= mclk;
    if (mclk && !mclk_q) bits <= #1 ~bits;
  end

  // overrange only while the bench asks, so error tests stay deterministic
  always @(posedge clk) ovr <= #1 ovr_req;

  initial bits = 1'h0;
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the decimator control and serial port block
`timescale 1ns/10ps

module tb;
  // ==========================================================
  // stimulus, outputs and bookkeeping
  reg clk = 1'h0;
  reg arst_n = 1'h0;
  reg chip_reset = 1'h0;
  reg decimator_reset = 1'h0;
  reg power_down = 1'h0;
  reg sync_in = 1'h0;
  reg hw_mode = 1'h1;
  reg [2:0] rate_select_pins = 3'h0;
  reg [4:0] modulator_control_pins = 5'h0;
  reg cs_n = 1'h1;
  reg sclk = 1'h0;
  reg read_not_write = 1'h0;
  reg register_select = 1'h0;
  reg din = 1'h0;
  reg master_clock_in = 1'h0;
  reg test_data_in = 1'h0;
  reg filter_source_select = 1'h0;
  reg result_strobe = 1'h0;
  reg [23:0] result_data = 24'h0;
  reg period_start = 1'h0;
  reg filter_error = 1'h0;
  reg ovr_req = 1'h0;
  wire dout_o, dout_oe, result_ready, fault_n_o, fault_n_oe, modulator_clock_out, filter_bit;
  wire filter_bit_strobe, filter_clear, decimator_hold, convolve_enable;
  wire modulator_bitstream_in, modulator_overrange_in;
  wire [4:0] modulator_control_out;
  wire [2:0] decimation_rate;
  wire dout_w = dout_oe ? dout_o : 1'hZ;
  wire fault_w = fault_n_oe ? fault_n_o : 1'h1; // shared line with pull-up
  integer seed = 32'hA69EFDBF;
  integer mismatches = 0;
  integer n_checks = 0;
  integer i, j, k;
  reg [23:0] q_exp [$];
  reg [23:0] got_w, w, msk;
  reg [7:0] v;
  reg b;
  event got_ev;

  // ==========================================================
  // clocks: system 4 ns, master clock 8 system cycles per period
  always #2 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    master_clock_in <= ~master_clock_in;
  end

  dcsp_top DUT (.clk, .arst_n, .ce(1'h1), .chip_reset, .decimator_reset, .power_down, .sync_in, .hw_mode,
    .rate_select_pins, .modulator_control_pins, .cs_n, .sclk, .read_not_write, .register_select, .din,
    .dout_o, .dout_oe, .result_ready, .fault_n_o, .fault_n_oe, .master_clock_in, .modulator_bitstream_in,
    .modulator_overrange_in, .test_data_in, .filter_source_select, .modulator_clock_out,
    .modulator_control_out, .result_strobe, .result_data, .period_start, .filter_error, .filter_bit,
    .filter_bit_strobe, .filter_clear, .decimator_hold, .convolve_enable, .decimation_rate);

  dcsp_mod_model u_mod (.clk, .mclk(modulator_clock_out), .ovr_req, .bits(modulator_bitstream_in),
    .ovr(modulator_overrange_in));

  // ==========================================================
  // helpers: inputs change one nanosecond after the edge, except the master clock, which toggles on it
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk_word(input [23:0] exp, input [23:0] got);
    n_checks = n_checks + 1;
    if (exp !== got) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  task chk_bit(input exp, input got);
    chk_word({23'h0, exp}, {23'h0, got});
  endtask

  // host read: sample each bit while the clock is low, then pulse it
  task sread(input sel, input integer n);
    cs_n = 1'h0;
    read_not_write = 1'h1;
    register_select = sel;
    w = 24'h0;
    tick(3);
    for (i = 0; i < n; i = i + 1) begin
      w = {w[22:0], dout_w};
      sclk = 1'h1;
      tick(3);
      sclk = 1'h0;
      tick(3);
    end
    cs_n = 1'h1;
    tick(2);
    chk_bit(1'h0, dout_oe);
    got_w = w & msk;
    -> got_ev;
  endtask

  // host write: n bits msb first, each held across its falling edge
  task swrite(input [7:0] val, input integer n);
    cs_n = 1'h0;
    read_not_write = 1'h0;
    for (i = 7; i > 7 - n; i = i - 1) begin
      din = val[i];
      sclk = 1'h1;
      tick(2);
      sclk = 1'h0;
      tick(2);
      chk_bit(1'h0, dout_oe);
    end
    cs_n = 1'h1;
    tick(3);
  endtask

  // ==========================================================
  // watcher: every finished read is matched against the oldest note
  always @(got_ev) chk_word(q_exp.pop_front(), got_w);

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog, well beyond the expected run of about a thousand cycles
  initial begin
    #200000;
    mismatches = mismatches + 1;
    close_out;
  end

  // ==========================================================
  // main sequence
  initial begin
    msk = 24'hFFFFFF;
    tick(10);
    arst_n = 1'h1;
    tick(2);
    for (k = 0; k < 4; k = k + 1) begin
      {rate_select_pins, modulator_control_pins} = $random(seed);
      tick(4);
      chk_word({rate_select_pins, modulator_control_pins}, {decimation_rate, modulator_control_out});
    end
    hw_mode = 1'h0;
    chip_reset = 1'h1;
    tick(2);
    chip_reset = 1'h0;
    tick(2);
    chk_word({rate_select_pins, modulator_control_pins}, {decimation_rate, modulator_control_out});
    v = $random(seed);
    swrite(v, 8);
    chk_word(v, {decimation_rate, modulator_control_out});
    swrite(~v, 3);
    chk_word(v, {decimation_rate, modulator_control_out});
    for (k = 0; k < 2; k = k + 1) begin
      result_data = $random(seed);
      result_strobe = 1'h1;
      tick(1);
      result_strobe = 1'h0;
      chk_bit(1'h1, result_ready);
      q_exp.push_back(result_data);
      sread(1'h1, 24);
      chk_bit(1'h0, result_ready);
    end
    filter_error = 1'h1;
    tick(1);
    filter_error = 1'h0;
    tick(2);
    chk_bit(1'h0, fault_w);
    msk = 24'hE4;
    q_exp.push_back(24'h84);
    sread(1'h0, 8);
    ovr_req = 1'h1;
    tick(12);
    ovr_req = 1'h0;
    msk = 24'h08;
    q_exp.push_back(24'h08);
    sread(1'h0, 8);
    chip_reset = 1'h1;
    tick(2);
    chip_reset = 1'h0;
    tick(2);
    chk_bit(1'h1, fault_w);
    decimator_reset = 1'h1;
    tick(3);
    chk_bit(1'h1, decimator_hold);
    decimator_reset = 1'h0;
    power_down = 1'h1;
    tick(20);
    b = modulator_clock_out;
    for (k = 0; k < 16; k = k + 1) begin
      tick(1);
      chk_bit(b, modulator_clock_out);
      chk_bit(1'h0, filter_bit_strobe);
    end
    msk = 24'h20;
    q_exp.push_back(24'h20);
    sread(1'h0, 8);
    // the chip reset above reloaded the serial config from the pins
    chk_word({rate_select_pins, modulator_control_pins}, {decimation_rate, modulator_control_out});
    power_down = 1'h0;
    tick(20);
    chk_bit(1'h0, convolve_enable);
    for (j = 0; j < 2; j = j + 1) begin
      period_start = j;
      sync_in = 1'h1;
      b = 1'h0;
      for (k = 0; k < 40; k = k + 1) begin
        tick(1);
        b = b | filter_clear;
      end
      sync_in = 1'h0;
      period_start = 1'h0;
      tick(4);
      chk_bit(j == 0, b);
    end
    chk_bit(1'h1, convolve_enable);
    j = 0;
    b = modulator_clock_out;
    for (k = 0; k < 320; k = k + 1) begin
      tick(1);
      if (modulator_clock_out === 1'h1 && b === 1'h0) j = j + 1;
      b = modulator_clock_out;
    end
    chk_word(24'h00000A, j[23:0]);
    // odd passes take test data, even ones the modulator bits; the source is noted mid-cycle,
    // away from the model's update just after the edge
    for (k = 0; k < 4; k = k + 1) begin
      filter_source_select = k[0];
      test_data_in = $random(seed);
      tick(12);
      for (j = 0; j < 40 && (j == 0 || filter_bit_strobe !== 1'h1); j = j + 1) begin
        @(negedge clk) b = filter_source_select ? test_data_in : modulator_bitstream_in;
        tick(1);
      end
      chk_bit(b, filter_bit);
    end
    tick(10);
    close_out;
  end
endmodule
